// ===== ascii_fe_pkg.sv
/*
 * Shared constants of the ASCII serial command front end: character codes,
 * register offsets, field positions, reset values and timing figures.
 * Assumes a single 100 MHz system clock.
 */
package ascii_fe_pkg;
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ      = 100_000_000;
    localparam int unsigned RESP_MS     = 100;
    localparam int unsigned RESP_CYCLES = CLK_HZ / 1000 * RESP_MS;
    localparam int unsigned MB_GAP_BITS = 35;
    localparam int unsigned FRAME_BITS  = 10;
    // ----------------------------------------------------------------
    // Link and sample rate codes
    // ----------------------------------------------------------------
    localparam logic [3:0] BAUD_2400   = 4'h4;
    localparam logic [3:0] BAUD_4800   = 4'h5;
    localparam logic [3:0] BAUD_9600   = 4'h6;
    localparam logic [3:0] BAUD_19200  = 4'h7;
    localparam logic [3:0] BAUD_38400  = 4'h8;
    localparam logic [3:0] BAUD_57600  = 4'h9;
    localparam logic [3:0] BAUD_115200 = 4'hA;
    localparam logic [1:0] RATE_DEFAULT = 2'h2;
    // ----------------------------------------------------------------
    // Characters
    // ----------------------------------------------------------------
    localparam logic [7:0] CH_CR     = 8'h0D;
    localparam logic [7:0] CH_PCT    = 8'h25;
    localparam logic [7:0] CH_DOLLAR = 8'h24;
    localparam logic [7:0] CH_HASH   = 8'h23;
    localparam logic [7:0] CH_AT     = 8'h40;
    // ----------------------------------------------------------------
    // Register map and reset values
    // ----------------------------------------------------------------
    localparam logic [6:0] OFS_CTRL = 7'h00;
    localparam logic [6:0] OFS_CFG  = 7'h04;
    localparam logic [6:0] OFS_RATE = 7'h08;
    localparam logic [6:0] OFS_DATA = 7'h0C;
    localparam logic [6:0] OFS_LEN  = 7'h10;
    localparam int unsigned BUF_BIT  = 6;
    localparam int unsigned CFG_BAUD = 8;
    localparam int unsigned CFG_CKS  = 12;
    localparam logic [7:0] ADDR_FACTORY = 8'h01;
    localparam logic [7:0] ADDR_DEFAULT = 8'h00;
    localparam int unsigned BUF_DEPTH = 16;
endpackage

// ===== ascii_serial_command_front_end.sv
/*
 * ASCII serial command front end: UART framing, address match, checksum,
 * character/binary protocol detection, reply sender, stored configuration.
 * Assumes i_rx is already synchronous, firmware answers accepted commands
 * over Avalon-MM and drives the RS-485 transceiver through o_tx/o_tx_en.
 */
// Our own choices: the placing of the registers and register access over Avalon-MM.
// What this block does
// - Characters use one start, eight data, one stop bit, no parity.
// - Bit rate selectable among 2400 to 115200 bps.
// - Hold 8-bit station address; act only on own address.
// - Reply must begin within 100 ms of an accepted command.
// - Detect character protocol versus binary frames and route accordingly.
// - Shipped configuration: address 01, 9600 bps, checksum off.
// - Strap low at power-up forces address 00, 9600 bps, checksum off.
// - Bit rate and checksum changes refused outside strap default state.
// - User configuration kept in storage surviving power cycles; here i_rst reloads the shipped values instead.
// - Command is prefix, address, command, data, optional checksum.
// - First character is prefix selecting class: % $ # @.
// - Address arrives as two hex digits, decoded to eight bits.
// - With checksum on, commands and replies carry two checksum chars.
// - Checksum chars sit right before the terminating carriage return.
// - Checksum is byte sum of preceding characters, two hex digits.
// - Sampling rate 2.5, 5, 10 or 20 per second, default 10.
// - Results derive from 12-bit converter samples.
// - Reply starts with ! or > when accepted, ? when invalid.
// - Every command and reply ends with carriage return 0DH.
// - No reply to malformed, errored or foreign-address messages.
`timescale 1ns/100ps
module ascii_serial_command_front_end #(
    parameter int unsigned P_CLK_HZ      = ascii_fe_pkg::CLK_HZ,
    parameter int unsigned P_RESP_CYCLES = ascii_fe_pkg::RESP_CYCLES
) (
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst,
    input  wire logic        i_rx,
    output logic             o_tx,
    output logic             o_tx_en,
    input  wire logic        i_default_strap_n,
    input  wire logic [11:0] i_adc_sample,
    input  wire logic        i_adc_valid,
    output logic             o_adc_start,
    input  wire logic [6:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    output logic [31:0]      o_avs_readdata,
    output logic             o_avs_waitrequest
);
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [4:0] hex_val(input logic [7:0] c);
        if (c >= 8'h30 && c <= 8'h39) return {1'b1, c[3:0]};
        if (c >= 8'h41 && c <= 8'h46) return {1'b1, 4'(c[3:0] + 4'h9)};
        return 5'h00;
    endfunction
    function automatic logic [7:0] hex_chr(input logic [3:0] n);
        return (n < 4'hA) ? {4'h3, n} : {4'h4, 4'(n - 4'h9)};
    endfunction
    function automatic logic [16:0] baud_div(input logic [3:0] code);
        unique case (code)
            ascii_fe_pkg::BAUD_2400:   return 17'(P_CLK_HZ / 2400);
            ascii_fe_pkg::BAUD_4800:   return 17'(P_CLK_HZ / 4800);
            ascii_fe_pkg::BAUD_19200:  return 17'(P_CLK_HZ / 19200);
            ascii_fe_pkg::BAUD_38400:  return 17'(P_CLK_HZ / 38400);
            ascii_fe_pkg::BAUD_57600:  return 17'(P_CLK_HZ / 57600);
            ascii_fe_pkg::BAUD_115200: return 17'(P_CLK_HZ / 115200);
            default:                   return 17'(P_CLK_HZ / 9600);
        endcase
    endfunction
    // ----------------------------------------------------------------
    // Configuration and bus slave
    // ----------------------------------------------------------------
    logic [7:0]  cfg_addr_q, cfg_addr_d, eff_addr;
    logic [3:0]  cfg_baud_q, cfg_baud_d, eff_baud;
    logic        cfg_cks_q, cfg_cks_d, eff_cks;
    logic [1:0]  rate_q, rate_d;
    logic        default_q, default_d, strap_done_q;
    logic        reject_q, reject_d, late_q, late_d;
    logic [11:0] adc_q, adc_d;
    logic        wait_q, wait_d;
    logic [31:0] rdata_q, rdata_d;
    logic [7:0]  txbuf_q [ascii_fe_pkg::BUF_DEPTH];
    logic [4:0]  tx_len_q, tx_len_d;
    logic        wr_en, rel_rx, start_tx;
    logic [16:0] div;
    logic [7:0]  rxbuf_q [ascii_fe_pkg::BUF_DEPTH];
    logic [4:0]  rx_len_q, rx_len_d;
    logic        rx_valid_q, rx_valid_d, rx_proto_q, rx_proto_d, tx_busy;

    assign wr_en    = i_avs_write && !wait_q;
    assign rel_rx   = wr_en && i_avs_address == ascii_fe_pkg::OFS_CTRL
                      && i_avs_writedata[0];
    assign start_tx = wr_en && i_avs_address == ascii_fe_pkg::OFS_CTRL
                      && i_avs_writedata[1] && !tx_busy;
    assign eff_addr = default_q ? ascii_fe_pkg::ADDR_DEFAULT : cfg_addr_q;
    assign eff_baud = default_q ? ascii_fe_pkg::BAUD_9600 : cfg_baud_q;
    assign eff_cks  = default_q ? 1'b0 : cfg_cks_q;
    assign div      = baud_div(eff_baud);

    always_comb begin
        cfg_addr_d = cfg_addr_q;
        cfg_baud_d = cfg_baud_q;
        cfg_cks_d  = cfg_cks_q;
        rate_d     = rate_q;
        reject_d   = reject_q;
        tx_len_d   = tx_len_q;
        adc_d      = i_adc_valid ? i_adc_sample : adc_q;
        default_d  = strap_done_q ? default_q : !i_default_strap_n;
        wait_d     = !((i_avs_read || i_avs_write) && wait_q);
        rdata_d    = rdata_q;
        if (wr_en) begin
            if (i_avs_address == ascii_fe_pkg::OFS_CFG) begin
                cfg_addr_d = i_avs_writedata[7:0];
                if (default_q) begin
                    cfg_baud_d = i_avs_writedata[ascii_fe_pkg::CFG_BAUD+:4];
                    cfg_cks_d  = i_avs_writedata[ascii_fe_pkg::CFG_CKS];
                end else begin
                    reject_d = 1'b1;
                end
            end
            if (i_avs_address == ascii_fe_pkg::OFS_RATE)
                rate_d = i_avs_writedata[1:0];
            if (i_avs_address == ascii_fe_pkg::OFS_LEN)
                tx_len_d = i_avs_writedata[4:0];
            if (i_avs_address == ascii_fe_pkg::OFS_CTRL
                && i_avs_writedata[3])
                reject_d = 1'b0;
        end
        if (i_avs_read && wait_q) begin
            rdata_d = 32'h0000_0000;
            if (i_avs_address[ascii_fe_pkg::BUF_BIT])
                rdata_d[7:0] = rxbuf_q[i_avs_address[5:2]];
            else unique case (i_avs_address)
                ascii_fe_pkg::OFS_CTRL: rdata_d[5:0] = {reject_q, late_q,
                    rx_proto_q, rx_valid_q, tx_busy, default_q};
                ascii_fe_pkg::OFS_CFG:  rdata_d[12:0] = {cfg_cks_q,
                    cfg_baud_q, cfg_addr_q};
                ascii_fe_pkg::OFS_RATE: rdata_d[1:0] = rate_q;
                ascii_fe_pkg::OFS_DATA: rdata_d[11:0] = adc_q;
                ascii_fe_pkg::OFS_LEN:  rdata_d[4:0] = rx_len_q;
                default:                rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            cfg_addr_q   <= ascii_fe_pkg::ADDR_FACTORY;
            cfg_baud_q   <= ascii_fe_pkg::BAUD_9600;
            cfg_cks_q    <= 1'b0;
            rate_q       <= ascii_fe_pkg::RATE_DEFAULT;
            default_q    <= 1'b0;
            strap_done_q <= 1'b0;
            reject_q     <= 1'b0;
            tx_len_q     <= 5'h00;
            adc_q        <= 12'h000;
            wait_q       <= 1'b1;
            rdata_q      <= 32'h0000_0000;
        end else begin
            cfg_addr_q   <= cfg_addr_d;
            cfg_baud_q   <= cfg_baud_d;
            cfg_cks_q    <= cfg_cks_d;
            rate_q       <= rate_d;
            default_q    <= default_d;
            strap_done_q <= 1'b1;
            reject_q     <= reject_d;
            tx_len_q     <= tx_len_d;
            adc_q        <= adc_d;
            wait_q       <= wait_d;
            rdata_q      <= rdata_d;
        end
        if (wr_en && i_avs_address[ascii_fe_pkg::BUF_BIT])
            txbuf_q[i_avs_address[5:2]] <= i_avs_writedata[7:0];
    end
    assign o_avs_waitrequest = wait_q;
    assign o_avs_readdata    = rdata_q;
    // ----------------------------------------------------------------
    // Receiver and command parser
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} rx_type;
    typedef enum logic [2:0] {P_PREFIX, P_ADDR_HI, P_ADDR_LO, P_BODY,
                              P_SKIP, P_BINARY} parse_type;
    rx_type      rx_q, rx_d;
    parse_type   ps_q, ps_d;
    logic [16:0] rcnt_q, rcnt_d;
    logic [2:0]  rbit_q, rbit_d;
    logic [7:0]  rsh_q, rsh_d, ahi_q, ahi_d, c1_q, c1_d, c2_q, c2_d;
    logic [7:0]  sum_q, sum_d, sum1_q, sum1_d, sum2_q, sum2_d;
    logic [22:0] gap_q, gap_d;
    logic [31:0] resp_q, resp_d;
    logic        stb, ferr, store, cks_ok;
    logic [4:0]  hv, hc1, hc2;

    assign hv     = hex_val(rsh_d);
    assign hc1    = hex_val(c1_q);
    assign hc2    = hex_val(c2_q);
    assign cks_ok = hc1[4] && hc2[4] && {hc2[3:0], hc1[3:0]} == sum2_q
                    && rx_len_q >= 5'd5;

    always_comb begin
        rx_d = rx_q;  rcnt_d = rcnt_q;  rbit_d = rbit_q;  rsh_d = rsh_q;
        stb  = 1'b0;  ferr = 1'b0;
        if (rx_q != RX_IDLE) rcnt_d = rcnt_q - 17'd1;
        unique case (rx_q)
            RX_IDLE: if (!i_rx) begin
                rx_d = RX_START;  rcnt_d = {1'b0, div[16:1]};
            end
            RX_START: if (rcnt_q == 17'd0) begin
                rx_d = i_rx ? RX_IDLE : RX_BITS;
                rcnt_d = div - 17'd1;  rbit_d = 3'd0;
            end
            RX_BITS: if (rcnt_q == 17'd0) begin
                rsh_d = {i_rx, rsh_q[7:1]};  rcnt_d = div - 17'd1;
                rbit_d = rbit_q + 3'd1;
                if (rbit_q == 3'd7) rx_d = RX_STOP;
            end
            RX_STOP: if (rcnt_q == 17'd0) begin
                rx_d = RX_IDLE;  stb = i_rx;  ferr = !i_rx;
            end
        endcase
    end

    always_comb begin
        ps_d = ps_q;  rx_len_d = rx_len_q;  ahi_d = ahi_q;  store = 1'b0;
        c1_d = c1_q;  c2_d = c2_q;  sum_d = sum_q;  sum1_d = sum1_q;
        sum2_d = sum2_q;  rx_proto_d = rx_proto_q;
        rx_valid_d = rx_valid_q && !rel_rx && !start_tx;
        late_d = late_q && !(rel_rx && 1'b0);
        if (wr_en && i_avs_address == ascii_fe_pkg::OFS_CTRL
            && i_avs_writedata[2]) late_d = 1'b0;
        gap_d  = (ps_q == P_BINARY && !stb) ? gap_q + 23'd1 : 23'd0;
        resp_d = (rx_valid_q && !rx_proto_q) ? resp_q + 32'd1 : 32'd0;
        if (resp_q >= P_RESP_CYCLES - 1) begin
            rx_valid_d = 1'b0;  late_d = 1'b1;
        end
        if (stb) begin
            sum2_d = sum1_q;  sum1_d = sum_q;  sum_d = sum_q + rsh_d;
            c2_d = c1_q;  c1_d = rsh_d;
            store = !rx_valid_q && rx_len_q < 5'd16;
            rx_len_d = store ? rx_len_q + 5'd1 : rx_len_q;
        end
        unique case (ps_q)
            P_PREFIX: if (stb) begin
                sum_d = rsh_d;  sum1_d = 8'h00;  sum2_d = 8'h00;
                store = !rx_valid_q;  rx_len_d = 5'd1;
                if (rsh_d == ascii_fe_pkg::CH_PCT
                    || rsh_d == ascii_fe_pkg::CH_DOLLAR
                    || rsh_d == ascii_fe_pkg::CH_HASH
                    || rsh_d == ascii_fe_pkg::CH_AT)
                    ps_d = P_ADDR_HI;
                else if (rsh_d != ascii_fe_pkg::CH_CR)
                    ps_d = P_BINARY;
            end
            P_ADDR_HI: if (stb) begin
                ahi_d = {4'h0, hv[3:0]};
                ps_d = hv[4] ? P_ADDR_LO : P_SKIP;
            end
            P_ADDR_LO: if (stb)
                ps_d = (hv[4] && {ahi_q[3:0], hv[3:0]} == eff_addr)
                       ? P_BODY : P_SKIP;
            P_BODY: if (stb && !store) ps_d = P_SKIP;
            P_SKIP: ;
            P_BINARY: if (gap_q >= 23'(div * ascii_fe_pkg::MB_GAP_BITS)) begin
                ps_d = P_PREFIX;
                if (!rx_valid_q) begin
                    rx_valid_d = 1'b1;  rx_proto_d = 1'b1;
                end
            end
        endcase
        if (stb && rsh_d == ascii_fe_pkg::CH_CR && ps_q != P_BINARY) begin
            ps_d = P_PREFIX;
            if (ps_q == P_BODY && !rx_valid_q && (!eff_cks || cks_ok)) begin
                rx_valid_d = 1'b1;  rx_proto_d = 1'b0;
                rx_len_d = eff_cks ? rx_len_q - 5'd2 : rx_len_q;
            end
        end
        if (ferr) ps_d = P_PREFIX;
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            rx_q <= RX_IDLE;  ps_q <= P_PREFIX;  rcnt_q <= 17'h00000;
            rbit_q <= 3'h0;  rsh_q <= 8'h00;  ahi_q <= 8'h00;
            c1_q <= 8'h00;  c2_q <= 8'h00;  sum_q <= 8'h00;
            sum1_q <= 8'h00;  sum2_q <= 8'h00;  rx_len_q <= 5'h00;
            rx_valid_q <= 1'b0;  rx_proto_q <= 1'b0;  late_q <= 1'b0;
            gap_q <= 23'h000000;  resp_q <= 32'h0000_0000;
        end else begin
            rx_q <= rx_d;  ps_q <= ps_d;  rcnt_q <= rcnt_d;
            rbit_q <= rbit_d;  rsh_q <= rsh_d;  ahi_q <= ahi_d;
            c1_q <= c1_d;  c2_q <= c2_d;  sum_q <= sum_d;
            sum1_q <= sum1_d;  sum2_q <= sum2_d;  rx_len_q <= rx_len_d;
            rx_valid_q <= rx_valid_d;  rx_proto_q <= rx_proto_d;
            late_q <= late_d;  gap_q <= gap_d;  resp_q <= resp_d;
        end
        if (store)
            rxbuf_q[(ps_q == P_PREFIX) ? 4'h0 : rx_len_q[3:0]] <= rsh_d;
    end
    // ----------------------------------------------------------------
    // Reply sender and sample pacing
    // ----------------------------------------------------------------
    typedef enum logic {T_IDLE, T_SEND} tx_type;
    tx_type      tx_q, tx_d;
    logic [5:0]  tidx_q, tidx_d, tlast;
    logic [3:0]  tbit_q, tbit_d;
    logic [16:0] tcnt_q, tcnt_d;
    logic [9:0]  tsh_q, tsh_d;
    logic [7:0]  tsum_q, tsum_d, tchr;
    logic        cks_q, cks_d;
    logic [25:0] scnt_q, scnt_d, speriod;
    logic        tx_d_pin, en_d, adc_d_start;

    assign tx_busy = (tx_q == T_SEND);
    assign tlast   = {1'b0, tx_len_q} + (cks_q ? 6'd2 : 6'd0);
    always_comb begin
        if (tidx_q < {1'b0, tx_len_q}) tchr = txbuf_q[tidx_q[3:0]];
        else if (tidx_q == tlast)      tchr = ascii_fe_pkg::CH_CR;
        else if (tidx_q == {1'b0, tx_len_q})
            tchr = hex_chr(tsum_q[7:4]);
        else
            tchr = hex_chr(tsum_q[3:0]);
    end

    always_comb begin
        tx_d = tx_q;  tidx_d = tidx_q;  tbit_d = tbit_q;  tcnt_d = tcnt_q;
        tsh_d = tsh_q;  tsum_d = tsum_q;  cks_d = cks_q;
        if (start_tx) begin
            tx_d = T_SEND;  tidx_d = 6'd0;  tbit_d = 4'd0;
            tsum_d = 8'h00;  cks_d = eff_cks;
        end else if (tx_q == T_SEND) begin
            if (tbit_q == 4'd0) begin
                tsh_d = {1'b1, tchr, 1'b0};
                tbit_d = 4'(ascii_fe_pkg::FRAME_BITS);
                tcnt_d = div - 17'd1;
                if (tidx_q < {1'b0, tx_len_q})
                    tsum_d = tsum_q + tchr;
            end else if (tcnt_q == 17'd0) begin
                tsh_d = {1'b1, tsh_q[9:1]};  tcnt_d = div - 17'd1;
                tbit_d = tbit_q - 4'd1;
                if (tbit_q == 4'd1) begin
                    tidx_d = tidx_q + 6'd1;
                    if (tidx_q == tlast) tx_d = T_IDLE;
                end
            end else begin
                tcnt_d = tcnt_q - 17'd1;
            end
        end
        tx_d_pin = (tx_d == T_SEND) ? tsh_d[0] : 1'b1;
        en_d     = (tx_d == T_SEND);
        unique case (rate_q)
            2'd0:    speriod = 26'(P_CLK_HZ * 2 / 5);
            2'd1:    speriod = 26'(P_CLK_HZ / 5);
            2'd2:    speriod = 26'(P_CLK_HZ / 10);
            default: speriod = 26'(P_CLK_HZ / 20);
        endcase
        adc_d_start = (scnt_q >= speriod - 26'd1);
        scnt_d      = adc_d_start ? 26'd0 : scnt_q + 26'd1;
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            tx_q <= T_IDLE;  tidx_q <= 6'h00;  tbit_q <= 4'h0;
            tcnt_q <= 17'h00000;  tsh_q <= 10'h3FF;  tsum_q <= 8'h00;
            cks_q <= 1'b0;  o_tx <= 1'b1;  o_tx_en <= 1'b0;
            scnt_q <= 26'h0000000;  o_adc_start <= 1'b0;
        end else begin
            tx_q <= tx_d;  tidx_q <= tidx_d;  tbit_q <= tbit_d;
            tcnt_q <= tcnt_d;  tsh_q <= tsh_d;  tsum_q <= tsum_d;
            cks_q <= cks_d;  o_tx <= tx_d_pin;  o_tx_en <= en_d;
            scnt_q <= scnt_d;  o_adc_start <= adc_d_start;
        end
    end
    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    sequence s_load;
        tx_q == T_SEND && tbit_q == 4'd0 && !start_tx;
    endsequence
    a_start_bit_low: assert property (s_load |=> !o_tx [*2])
        else $error("start bit not low");
    a_stop_bit_high: assert property (tx_q == T_SEND && tbit_q == 4'd1
        |-> tsh_q[0])
        else $error("stop bit not high");
    a_strap_default: assert property (default_q |-> eff_addr == 8'h00
        && div == 17'(P_CLK_HZ / 9600) && !eff_cks)
        else $error("strap default not applied");
    a_cfg_locked: assert property (!default_q && wr_en
        && i_avs_address == ascii_fe_pkg::OFS_CFG
        |=> $stable(cfg_baud_q) && $stable(cfg_cks_q) && reject_q)
        else $error("locked setting changed");
    a_reply_bound: assert property (rx_valid_q && !rx_proto_q
        |-> resp_q < P_RESP_CYCLES)
        else $error("reply wait exceeded");
    a_cr_restart: assert property (stb && rsh_d == ascii_fe_pkg::CH_CR
        && ps_q != P_BINARY |=> ps_q == P_PREFIX)
        else $error("parser not restarted");
    a_foreign_addr: assert property (ps_q == P_ADDR_LO && stb
        && rsh_d != ascii_fe_pkg::CH_CR
        && {ahi_q[3:0], hv[3:0]} != eff_addr |=> ps_q == P_SKIP)
        else $error("foreign address accepted");
    a_ends_with_cr: assert property ((s_load and tidx_q == tlast)
        |-> tchr == ascii_fe_pkg::CH_CR)
        else $error("reply not ended by CR");
    a_bus_answer: assert property ((i_avs_read || i_avs_write) && wait_q
        |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
        else $error("bus answer not one cycle");
endmodule

// ===== ascii_host_model.sv
/* Host model on the RS-485 side: sends and receives 8N1 characters.
   Assumes the bench calls its tasks; the bias keeps the idle line high. */
`timescale 1ns/100ps
module ascii_host_model #(
    parameter int BIT = 104
) (
    input  wire logic i_clk,
    input  wire logic i_tx,
    input  wire logic i_tx_en,
    output logic      o_line
);
    initial o_line = 1'b1;
    // Start bit, eight data bits LSB first, one stop bit
    task automatic send(input logic [7:0] c);
        logic [9:0] f;
        f = {1'b1, c, 1'b0};
        for (int i = 0; i < 10; i++) begin
            o_line <= f[i];
            repeat (BIT) @(posedge i_clk);
        end
    endtask
    // Samples mid-bit; stop bit returned in bit 8
    task automatic get(output logic [8:0] c);
        while (!(i_tx_en === 1'b1 && i_tx === 1'b0)) @(posedge i_clk);
        repeat (BIT / 2) @(posedge i_clk);
        for (int i = 0; i < 9; i++) begin
            repeat (BIT) @(posedge i_clk);
            c[i] = i_tx;
        end
    endtask
endmodule

// ===== ascii_serial_command_front_end_test.sv
/* Self-checking bench of the ASCII serial command front end.
   Assumes P_CLK_HZ of 1 MHz so one bit at 9600 bps is 104 cycles. */
`timescale 1ns/100ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fail_count++; \
    $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module ascii_serial_command_front_end_test;
    logic        clk, rst, line, tx, tx_en, rd, wr, wait_q, strap_n;
    logic [6:0]  adr;
    logic [31:0] wd, rdata, q;
    logic [11:0] smp;
    logic        vld;
    logic [8:0]  c;
    int          fail_count, comparisons, seed;
    ascii_host_model host (.i_clk(clk), .i_tx(tx), .i_tx_en(tx_en),
        .o_line(line));
    ascii_serial_command_front_end #(.P_CLK_HZ(1_000_000),
        .P_RESP_CYCLES(2000)) ascii_serial_command_front_end_inst (
        .i_ref_clk(clk), .i_rst(rst), .i_rx(line), .o_tx(tx),
        .o_tx_en(tx_en), .i_default_strap_n(strap_n), .i_adc_sample(smp),
        .i_adc_valid(vld), .o_adc_start(), .i_avs_address(adr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wait_q));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ------------------------------------------------------------
    // Bus, link and verdict helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] cfg(logic [7:0] a, logic [3:0] b);
        return {20'h0, b, a};
    endfunction
    // Reply written by firmware: '!' then the address digits '0' '1'
    function automatic logic [7:0] reply_chr(int i);
        return (i == 0) ? 8'h21 : 8'(8'h2F + i);
    endfunction
    task automatic bus(input bit w, input logic [6:0] a, input logic [31:0] d);
        @(posedge clk);
        rd <= !w; wr <= w; adr <= a; wd <= d;
        do @(posedge clk); while (wait_q !== 1'b0);
        q = rdata;
        rd <= 1'b0; wr <= 1'b0;
    endtask
    // Upper-case command, carriage return last
    task automatic cmd(input string s);
        for (int i = 0; i < s.len(); i++) host.send(s[i]);
        host.send(ascii_fe_pkg::CH_CR);
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        fail_count++;
        give_verdict;
    end
    initial begin
        seed = 67076; rst = 1'b1; rd = 1'b0; wr = 1'b0; adr = 7'h00;
        wd = 32'h0; smp = 12'h000; vld = 1'b0; comparisons = 0; fail_count = 0;
        strap_n = 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        bus(0, ascii_fe_pkg::OFS_CFG, 0); `CHK(q, cfg(8'h01, 4'h6))
        bus(0, ascii_fe_pkg::OFS_RATE, 0); `CHK(q, 32'h2)
        $display("reset values done");
        cmd("#01");
        bus(0, ascii_fe_pkg::OFS_CTRL, 0); `CHK(q[2], 1'b1)
        bus(0, ascii_fe_pkg::OFS_LEN, 0); `CHK(q, 32'h3)
        bus(0, 7'h40, 0); `CHK(q[7:0], ascii_fe_pkg::CH_HASH)
        bus(1, ascii_fe_pkg::OFS_CTRL, 32'h1);
        cmd("#02");
        bus(0, ascii_fe_pkg::OFS_CTRL, 0); `CHK(q[2], 1'b0)
        $display("address match done");
        bus(1, ascii_fe_pkg::OFS_CFG, 32'h1801);
        bus(0, ascii_fe_pkg::OFS_CFG, 0); `CHK(q, cfg(8'h01, 4'h6))
        bus(0, ascii_fe_pkg::OFS_CTRL, 0); `CHK(q[5], 1'b1)
        $display("refused config done");
        bus(1, 7'h40, 32'h21); bus(1, 7'h44, 32'h30); bus(1, 7'h48, 32'h31);
        bus(1, ascii_fe_pkg::OFS_LEN, 32'h3);
        bus(1, ascii_fe_pkg::OFS_CTRL, 32'h2);
        for (int i = 0; i < 3; i++) begin
            host.get(c); `CHK(c[7:0], reply_chr(i))
            `CHK(c[8], 1'b1)
        end
        host.get(c); `CHK(c, {1'b1, ascii_fe_pkg::CH_CR})
        $display("reply done");
        repeat (4) begin
            @(posedge clk);
            smp <= 12'($random(seed)); vld <= 1'b1;
            @(posedge clk);
            vld <= 1'b0;
            bus(0, ascii_fe_pkg::OFS_DATA, 0); `CHK(q, {20'h0, smp})
        end
        $display("sample done");
        // Power up again with the strap tied low
        strap_n <= 1'b0; rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        bus(0, ascii_fe_pkg::OFS_CTRL, 0); `CHK(q[5:0], 6'h01)
        bus(0, ascii_fe_pkg::OFS_CFG, 0); `CHK(q, cfg(8'h01, 4'h6))
        bus(1, ascii_fe_pkg::OFS_CFG, 32'h1705);
        bus(0, ascii_fe_pkg::OFS_CFG, 0); `CHK(q, 32'h1705)
        cmd("#00");
        bus(0, ascii_fe_pkg::OFS_CTRL, 0); `CHK(q[5:0], 6'h05)
        // Left unanswered past the reply limit
        repeat (2100) @(posedge clk);
        bus(0, ascii_fe_pkg::OFS_CTRL, 0); `CHK(q[5:0], 6'h11)
        // Non-prefix byte then a long idle gap is a binary frame
        host.send(8'h03);
        repeat (3700) @(posedge clk);
        bus(0, ascii_fe_pkg::OFS_CTRL, 0); `CHK(q[5:0], 6'h1D)
        $display("default state done");
        give_verdict;
    end
endmodule
